// >>> rtl/fcb_host_bus_unit.sv
// Coprocessor host bus unit: interface registers on an async host bus,
// sequencing to the execution unit, state save/restore.
// Assumes the execution unit runs on i_clk; host pins are asynchronous.
//
// Contract
// - Works on 8, 16 or 32 bit host buses.
// - Host talks only through memory-addressed interface registers.
// - Response encodes fetches or stores the host must perform.
// - New command before operand hand-over gets a wait response.
// - Device chooses concurrent or non-concurrent execution per instruction.
// - Never bus master; host moves all operands and results.
// - Device clock is unrelated to host clock; pins are synchronised.
// - Save request halts work, even mid-instruction, and supplies state.
// - Save in reset state yields a single null format word.
// - Idle save gives a short frame; busy save gives full state.
// - Short concurrent instruction finishes first, then idle frame is saved.
// - Restore reloads a frame and resumes any suspended operation.
// - Restoring the null frame acts as a hardware reset.
// - Frames are 32 bytes larger and carry a distinctive format word.
// - Trace and single-step work across coprocessor instructions.
// - Seven operand formats, byte to packed decimal.
`timescale 1ns/1ps
`default_nettype none

module fcb_host_bus_unit (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   // Host bus pins, asynchronous to i_clk
   input wire logic i_cs_n,
   input wire logic i_ds_n,
   input wire logic i_rw,
   input wire logic [2:0] i_addr,
   input wire logic [1:0] i_port_width,
   input wire logic [31:0] i_data,
   output logic [31:0] o_data,
   output logic o_data_oe_n,
   output logic [1:0] o_ack_n,
   // Execution unit hand-over
   output logic o_exec_start,
   output logic [15:0] o_exec_cmd,
   output logic [95:0] o_exec_operand,
   input wire logic i_exec_accept,
   input wire logic i_exec_busy,
   input wire logic i_exec_short,
   output logic o_exec_halt,
   output logic o_exec_resume,
   output logic o_exec_reset,
   // Result and state words
   output logic [5:0] o_word_idx,
   input wire logic [31:0] i_word,
   output logic o_state_load,
   output logic [5:0] o_load_idx,
   output logic [31:0] o_load_word
);
   import fcb_pkg::*;

   fcb_state_s st_reg;
   fcb_state_s st_next;

   // Operand length in long words per format
   // seven operand formats
   function automatic logic [1:0] fmt_words(input logic [2:0] fmt);
      logic [1:0] n;
      n = 2'd1;
      case (fmt)
         FMT_DOUBLE: n = 2'd2;
         FMT_EXTENDED, FMT_PACKED: n = 2'd3;
         default: n = 2'd1; // Byte, word, long, single
      endcase
      return n;
   endfunction : fmt_words

   // Next-state logic for the whole block
   always_comb begin
      logic [2:0] bpa;
      logic [1:0] ackw;
      logic last;
      logic take;
      logic save_hold;
      logic busy_now;
      logic [31:0] wword;
      logic [31:0] rval;
      logic [31:0] rcur;
      logic [7:0] fsize;
      bpa = 3'd4;
      ackw = ACK_32_N;
      last = 1'b0;
      take = 1'b0;
      save_hold = 1'b0;
      busy_now = 1'b0;
      wword = '0;
      rval = '0;
      rcur = '0;
      fsize = '0;
      st_next = st_reg;
      st_next.exec_reset = 1'b0;
      st_next.exec_resume = 1'b0;
      st_next.state_load = 1'b0;

      st_next.cs_s1 = i_cs_n;
      st_next.cs_s2 = st_reg.cs_s1;
      st_next.ds_s1 = i_ds_n;
      st_next.ds_s2 = st_reg.ds_s1;
      st_next.rw_s1 = i_rw;
      st_next.rw_s2 = st_reg.rw_s1;
      st_next.addr_s1 = i_addr;
      st_next.addr_s2 = st_reg.addr_s1;
      st_next.data_s1 = i_data;
      st_next.data_s2 = st_reg.data_s1;
      st_next.pw_s1 = i_port_width;
      st_next.pw_s2 = st_reg.pw_s1;

      // bytes per access for the strapped width
      case (st_reg.pw_s2)
         PW_16: begin
            bpa = 3'd2;
            ackw = ACK_16_N;
         end
         PW_8: begin
            bpa = 3'd1;
            ackw = ACK_8_N;
         end
         default: begin
            bpa = 3'd4;
            ackw = ACK_32_N;
         end
      endcase
      last = (st_reg.bcnt + bpa) >= 3'd4;

      // Narrow buses use the upper lanes, most significant first
      case (bpa)
         3'd2: wword = {st_reg.wacc[15:0], st_reg.data_s2[31:16]};
         3'd1: wword = {st_reg.wacc[23:0], st_reg.data_s2[31:24]};
         default: wword = st_reg.data_s2;
      endcase

      // Read values, frozen at a word's first lane
      busy_now = (st_reg.seq != S_IDLE) || i_exec_busy;
      case (st_reg.addr_s2)
         IDX_RESPONSE: begin
            // wait while a command is queued, or during hand-over, execution or a frame transfer
            if (st_reg.pend_valid || st_reg.seq == S_HAND || st_reg.seq == S_EXEC || st_reg.seq == S_FRAME) begin
               rval = RSP_WAIT;
            end else if (st_reg.seq == S_FETCH) begin
               rval = RSP_XFER_IN | {30'h0, st_reg.need - st_reg.widx};
            end else if (st_reg.seq == S_STORE) begin
               rval = RSP_XFER_OUT | {30'h0, st_reg.need - st_reg.fidx[1:0]};
            end else begin
               rval = st_reg.done_flag ? RSP_NULL_DONE : RSP_NULL_GO;
            end
         end
         IDX_CONTROL: rval = {22'h0, st_reg.trace, st_reg.halt, st_reg.reset_state, st_reg.pend_valid, st_reg.seq};
         IDX_SAVE: begin
            if (st_reg.reset_state) begin
               rval = '0;
            end else begin
               rval = {FRAME_VERSION, busy_now ? BUSY_WORDS : IDLE_WORDS, st_reg.cmd};
            end
         end
         IDX_OPERAND: rval = (st_reg.seq == S_STORE || st_reg.seq == S_FRAME) ? i_word : 32'h0;
         default: rval = '0; // Unmapped and write-only read zero
      endcase
      rcur = (st_reg.bcnt == 3'd0) ? rval : st_reg.rword;

      // hold a save read off while a short instruction completes
      save_hold = st_reg.rw_s2 && (st_reg.addr_s2 == IDX_SAVE) && (st_reg.bcnt == 3'd0)
                  && i_exec_busy && i_exec_short;
      take = (st_reg.bus == B_IDLE) && !st_reg.cs_s2 && !st_reg.ds_s2 && !save_hold;

      // Sequencer steps that need no host access
      case (st_reg.seq)
         S_IDLE: begin
            if (st_reg.pend_valid) begin
               st_next.cmd = st_reg.pend_cmd;
               st_next.pend_valid = 1'b0;
               st_next.halt = 1'b0;
               st_next.done_flag = 1'b0;
               st_next.need = fmt_words(st_reg.pend_cmd[CMD_FMT_LSB +: 3]);
               st_next.widx = '0;
               st_next.fidx = '0;
               // results are stored by the host after execution
               if (st_reg.pend_cmd[CMD_DIR_BIT]) begin
                  st_next.exec_start = 1'b1;
                  st_next.seq = S_HAND;
               end else begin
                  st_next.seq = S_FETCH;
               end
            end
         end
         S_HAND: begin
            if (i_exec_accept) begin
               st_next.exec_start = 1'b0;
               st_next.seq = (st_reg.cmd[CMD_DIR_BIT] || st_reg.trace) ? S_EXEC : S_IDLE;
            end
         end
         S_EXEC: begin
            if (!i_exec_busy && !st_reg.halt) begin
               st_next.seq = st_reg.cmd[CMD_DIR_BIT] ? S_STORE : S_IDLE;
               st_next.done_flag = !st_reg.cmd[CMD_DIR_BIT];
            end
         end
         default: ; // Advance on host accesses
      endcase

      // Host handshake; actions fire on a word's last lane
      case (st_reg.bus)
         B_IDLE: begin
            if (take) begin
               st_next.bus = B_ACK;
               st_next.ack_n = ackw;
               st_next.bcnt = last ? 3'd0 : st_reg.bcnt + bpa;
               if (st_reg.rw_s2) begin
                  st_next.rword = rcur;
                  st_next.dout = rcur << {st_reg.bcnt, 3'b000};
                  st_next.oe_n = 1'b0;
               end else begin
                  st_next.wacc = wword;
               end
               if (last && st_reg.rw_s2) begin
                  case (st_reg.addr_s2)
                     IDX_RESPONSE: begin
                        if (st_reg.seq == S_IDLE && !st_reg.pend_valid) begin
                           st_next.done_flag = 1'b0;
                        end
                     end
                     IDX_SAVE: begin
                        fsize = rcur[23:16];
                        if (rcur[31:24] != 8'h0) begin
                           st_next.halt = (fsize == BUSY_WORDS);
                           st_next.frame_busy = (fsize == BUSY_WORDS);
                           st_next.frame_left = 6'(fsize - 8'd1);
                           st_next.fidx = '0;
                           st_next.exec_start = 1'b0;
                           st_next.pend_valid = 1'b0;
                           st_next.seq = S_FRAME;
                        end
                     end
                     IDX_OPERAND: begin
                        if (st_reg.seq == S_STORE) begin
                           st_next.fidx = st_reg.fidx + 6'd1;
                           if (st_reg.fidx[1:0] + 2'd1 == st_reg.need) begin
                              st_next.seq = S_IDLE;
                              st_next.done_flag = 1'b1;
                           end
                        end else if (st_reg.seq == S_FRAME && !st_reg.reset_state) begin
                           st_next.fidx = st_reg.fidx + 6'd1;
                           st_next.frame_left = st_reg.frame_left - 6'd1;
                           if (st_reg.frame_left == 6'd1) begin
                              st_next.seq = S_IDLE; // Halt stays until restore or next command
                           end
                        end
                     end
                     default: ;
                  endcase
               end else if (last) begin
                  case (st_reg.addr_s2)
                     IDX_COMMAND: begin
                        // command taken, then queued for the sequencer
                        // response reports wait until this one is taken
                        st_next.pend_cmd = wword[15:0];
                        st_next.pend_valid = 1'b1;
                        st_next.reset_state = 1'b0;
                        st_next.done_flag = 1'b0;
                     end
                     IDX_CONTROL: st_next.trace = wword[0];
                     IDX_RESTORE: begin
                        if (wword[31:24] == 8'h0) begin
                           st_next.seq = S_IDLE;
                           st_next.pend_valid = 1'b0;
                           st_next.done_flag = 1'b0;
                           st_next.trace = 1'b0;
                           st_next.halt = 1'b0;
                           st_next.exec_start = 1'b0;
                           st_next.reset_state = 1'b1;
                           st_next.exec_reset = 1'b1;
                        end else begin
                           st_next.frame_busy = (wword[23:16] == BUSY_WORDS);
                           st_next.frame_left = 6'(wword[23:16] - 8'd1);
                           st_next.cmd = wword[15:0];
                           st_next.fidx = '0;
                           st_next.halt = 1'b1;
                           st_next.reset_state = 1'b0;
                           st_next.pend_valid = 1'b0;
                           st_next.seq = S_FRAME;
                        end
                     end
                     IDX_OPERAND: begin
                        if (st_reg.seq == S_FETCH) begin
                           st_next.operand = {st_reg.operand[63:0], wword};
                           st_next.widx = st_reg.widx + 2'd1;
                           if (st_reg.widx + 2'd1 == st_reg.need) begin
                              st_next.exec_start = 1'b1;
                              st_next.seq = S_HAND;
                           end
                        end else if (st_reg.seq == S_FRAME) begin
                           st_next.state_load = 1'b1;
                           st_next.load_word = wword;
                           st_next.load_idx = st_reg.fidx;
                           st_next.fidx = st_reg.fidx + 6'd1;
                           st_next.frame_left = st_reg.frame_left - 6'd1;
                           if (st_reg.frame_left == 6'd1) begin
                              st_next.halt = 1'b0;
                              st_next.exec_resume = st_reg.frame_busy;
                              st_next.seq = st_reg.frame_busy ? S_EXEC : S_IDLE;
                           end
                        end
                     end
                     default: ;
                  endcase
               end
            end
         end
         B_ACK: begin
            // Hold the acknowledge until the host lifts its strobe
            if (st_reg.ds_s2) begin
               st_next.bus = B_IDLE;
               st_next.ack_n = ACK_NONE_N;
               st_next.oe_n = 1'b1;
            end
         end
         default: begin
            st_next.bus = B_IDLE;
            st_next.ack_n = ACK_NONE_N;
            st_next.oe_n = 1'b1;
         end
      endcase
   end

   // All state in one register; enable freezes it
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st_reg <= ST_RESET;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   // Registered outputs
   assign o_data = st_reg.dout;
   assign o_data_oe_n = st_reg.oe_n;
   assign o_ack_n = st_reg.ack_n;
   assign o_exec_start = st_reg.exec_start;
   assign o_exec_cmd = st_reg.cmd;
   assign o_exec_operand = st_reg.operand;
   assign o_exec_halt = st_reg.halt;
   assign o_exec_resume = st_reg.exec_resume;
   assign o_exec_reset = st_reg.exec_reset;
   assign o_word_idx = st_reg.fidx;
   assign o_state_load = st_reg.state_load;
   assign o_load_idx = st_reg.load_idx;
   assign o_load_word = st_reg.load_word;

endmodule : fcb_host_bus_unit

`default_nettype wire

// >>> pkg/fcb_pkg.sv
// Constants, enums and state record of the coprocessor host bus unit.
// Assumes a core clock unrelated to the host bus timing.
package fcb_pkg;

   // Port width strap and acknowledge codes, {ack1,ack0} active low
   localparam logic [1:0] PW_32 = 2'h0;
   localparam logic [1:0] PW_16 = 2'h1;
   localparam logic [1:0] PW_8 = 2'h2;
   localparam logic [1:0] ACK_32_N = 2'h0;
   localparam logic [1:0] ACK_16_N = 2'h1;
   localparam logic [1:0] ACK_8_N = 2'h2;
   localparam logic [1:0] ACK_NONE_N = 2'h3;

   // Register indices on the low address lines
   localparam logic [2:0] IDX_RESPONSE = 3'h0;
   localparam logic [2:0] IDX_CONTROL = 3'h1;
   localparam logic [2:0] IDX_SAVE = 3'h2;
   localparam logic [2:0] IDX_RESTORE = 3'h3;
   localparam logic [2:0] IDX_COMMAND = 3'h4;
   localparam logic [2:0] IDX_OPERAND = 3'h5;

   // Command fields: direction bit and format
   localparam int CMD_DIR_BIT = 13;
   localparam int CMD_FMT_LSB = 10;
   localparam logic [2:0] FMT_LONG = 3'h0;
   localparam logic [2:0] FMT_SINGLE = 3'h1;
   localparam logic [2:0] FMT_EXTENDED = 3'h2;
   localparam logic [2:0] FMT_PACKED = 3'h3;
   localparam logic [2:0] FMT_WORD = 3'h4;
   localparam logic [2:0] FMT_DOUBLE = 3'h5;
   localparam logic [2:0] FMT_BYTE = 3'h6;

   // Response words; the low byte of a transfer request carries the word count
   localparam logic [31:0] RSP_NULL_GO = 32'h0000_0800;
   localparam logic [31:0] RSP_NULL_DONE = 32'h0000_0802;
   localparam logic [31:0] RSP_WAIT = 32'h0000_8900;
   localparam logic [31:0] RSP_XFER_IN = 32'h0000_1500;
   localparam logic [31:0] RSP_XFER_OUT = 32'h0000_3100;

   // Save frame: {version, words, command}; version zero is the null frame
   localparam logic [7:0] FRAME_VERSION = 8'h3c; // Arbitrary value
   localparam int FRAME_GROWTH_BYTES = 32;
   localparam int BASE_IDLE_BYTES = 28;
   localparam int BASE_BUSY_BYTES = 180;
   localparam logic [7:0] IDLE_WORDS = 8'((BASE_IDLE_BYTES + FRAME_GROWTH_BYTES) / 4);
   localparam logic [7:0] BUSY_WORDS = 8'((BASE_BUSY_BYTES + FRAME_GROWTH_BYTES) / 4);

   typedef enum logic [1:0] {
      B_IDLE = 2'b01,
      B_ACK = 2'b10
   } fcb_bus_e;

   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_FETCH = 6'b000010,
      S_HAND = 6'b000100,
      S_EXEC = 6'b001000,
      S_STORE = 6'b010000,
      S_FRAME = 6'b100000
   } fcb_seq_e;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic ds_s1;
      logic ds_s2;
      logic rw_s1;
      logic rw_s2;
      logic [2:0] addr_s1;
      logic [2:0] addr_s2;
      logic [31:0] data_s1;
      logic [31:0] data_s2;
      logic [1:0] pw_s1;
      logic [1:0] pw_s2;
      fcb_bus_e bus;
      logic [2:0] bcnt;
      logic [31:0] wacc;
      logic [31:0] rword;
      logic [31:0] dout;
      logic oe_n;
      logic [1:0] ack_n;
      fcb_seq_e seq;
      logic [15:0] cmd;
      logic [1:0] need;
      logic [1:0] widx;
      logic [95:0] operand;
      logic pend_valid;
      logic [15:0] pend_cmd;
      logic done_flag;
      logic trace;
      logic reset_state;
      logic halt;
      logic frame_busy;
      logic [5:0] frame_left;
      logic [5:0] fidx;
      logic [5:0] load_idx;
      logic exec_start;
      logic exec_reset;
      logic exec_resume;
      logic state_load;
      logic [31:0] load_word;
   } fcb_state_s;

   localparam fcb_state_s ST_RESET = '{cs_s1: 1'b1, cs_s2: 1'b1, ds_s1: 1'b1, ds_s2: 1'b1,
      rw_s1: 1'b1, rw_s2: 1'b1, bus: B_IDLE, oe_n: 1'b1, ack_n: ACK_NONE_N, seq: S_IDLE,
      reset_state: 1'b1, default: '0};

endpackage : fcb_pkg

// >>> testbench/fcb_host_bus_unit_sva.sv
// Port checks for the coprocessor host bus unit.
// Assumes i_ce is held high.
`timescale 1ns/1ps
`default_nettype none
module fcb_host_bus_unit_sva
   import fcb_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Host bus
   input wire logic i_cs_n,
   input wire logic i_ds_n,
   input wire logic [1:0] i_port_width,
   input wire logic o_data_oe_n,
   input wire logic [1:0] o_ack_n,
   // Execution side
   input wire logic o_exec_start,
   input wire logic [15:0] o_exec_cmd,
   input wire logic [95:0] o_exec_operand,
   input wire logic i_exec_accept,
   input wire logic o_exec_halt,
   input wire logic o_exec_resume,
   input wire logic o_exec_reset,
   input wire logic o_state_load
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Bus answers to a synchronised strobe, sized to the strap
   a_ack_reset: assert property ($rose(i_reset_n) |-> o_ack_n == ACK_NONE_N && o_data_oe_n)
      else $error("bus driven right after reset");
   a_ack_cause: assert property (o_ack_n != ACK_NONE_N && $past(o_ack_n) == ACK_NONE_N |-> $past(!i_cs_n && !i_ds_n, 3))
      else $error("acknowledge without a synchronised strobe");
   a_ack_width: assert property (o_ack_n != ACK_NONE_N |-> o_ack_n == i_port_width)
      else $error("acknowledge code does not match port width");
   a_ack_release: assert property ($past(i_reset_n) && $past(o_ack_n) != ACK_NONE_N && o_ack_n == ACK_NONE_N
      |-> $past(i_ds_n, 2))
      else $error("acknowledge dropped while strobe still low");
   a_oe_in_ack: assert property (!o_data_oe_n |-> o_ack_n != ACK_NONE_N)
      else $error("data driven outside an acknowledged read");
   // Hand-over and pulse outputs
   a_start_hold: assert property (o_exec_start && !i_exec_accept
      |=> o_exec_start && $stable(o_exec_cmd) && $stable(o_exec_operand))
      else $error("hand-over changed before accept");
   a_resume_pulse: assert property (o_exec_resume |=> !o_exec_resume)
      else $error("resume longer than one cycle");
   a_reset_pulse: assert property (o_exec_reset |=> !o_exec_reset && !o_exec_start)
      else $error("null restore reset not a clean pulse");
   a_load_pulse: assert property (o_state_load |=> !o_state_load)
      else $error("state load longer than one cycle");
   c_resume: cover property (o_exec_resume);
   c_reset: cover property (o_exec_reset);
   c_halt: cover property ($rose(o_exec_halt));
endmodule : fcb_host_bus_unit_sva
`default_nettype wire

// >>> testbench/fcb_host_model.sv
// Host bus master model: memory-style register accesses, lane by lane.
// Assumes the width strap matches the lane count.
`timescale 1ns/1ps
`default_nettype none
module fcb_host_model (
   // Clock and device answer
   input wire logic i_clk,
   input wire logic [1:0] i_ack_n,
   input wire logic [31:0] i_rdata,
   // Request lines
   output logic o_cs_n = 1'b1,
   output logic o_ds_n = 1'b1,
   output logic o_rw = 1'b1,
   output logic [2:0] o_addr = 3'h0,
   output logic [31:0] o_data = 32'h0
);
   int timeouts = 0;
   // decoded select, memory-style access
   // Request held until acknowledge; released data inverted
   task automatic access(input logic wr, input logic [2:0] idx, input logic [31:0] wd, input int lanes,
      output logic [31:0] rd, output logic [1:0] ack);
      int n;
      rd = '0;
      for (int l = 0; l < lanes; l++) begin
         @(posedge i_clk);
         #1;
         o_cs_n = 1'b0;
         o_ds_n = 1'b0;
         o_rw = !wr;
         o_addr = idx;
         o_data = wd << (l * 32 / lanes);
         n = 0;
         do begin
            @(posedge i_clk);
            n++;
         end while (i_ack_n == 2'h3 && n < 400);
         ack = i_ack_n;
         rd = (rd << (32 / lanes)) | (i_rdata >> (32 - 32 / lanes));
         #1;
         o_cs_n = 1'b1;
         o_ds_n = 1'b1;
         o_data = ~o_data;
         do begin
            @(posedge i_clk);
            n++;
         end while (i_ack_n != 2'h3 && n < 800);
         if (n >= 400) timeouts++;
      end
      #1;
   endtask : access
endmodule : fcb_host_model
`default_nettype wire

// >>> testbench/tb_fcb_host_bus_unit.sv
// Bench for the host bus unit: host model, execution unit model, reference checks.
// Assumes a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_fcb_host_bus_unit;
   import fcb_pkg::*;
   logic i_clk = 1'b0, i_reset_n = 1'b0, i_exec_accept = 1'b0, i_exec_busy = 1'b0, i_exec_short = 1'b0;
   logic hold_acc = 1'b0, hold_busy = 1'b0, cs_n, ds_n, rw, o_data_oe_n, o_exec_start, o_exec_halt;
   logic o_exec_resume, o_exec_reset, o_state_load;
   logic [1:0] i_port_width = PW_32, o_ack_n;
   logic [2:0] addr;
   logic [5:0] o_word_idx;
   logic [15:0] o_exec_cmd, cmd;
   logic [31:0] wdata, o_data, i_word, rd, frame;
   logic [95:0] o_exec_operand;
   logic [31:0] q[$];
   int num_errors = 0, checks = 0, lanes = 1, bcnt = 0, loads = 0, resumes = 0, resets = 0;
   // Clock generator
   initial forever #5 i_clk = ~i_clk;
   fcb_host_bus_unit i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1), .i_cs_n(cs_n), .i_ds_n(ds_n),
      .i_rw(rw), .i_addr(addr), .i_port_width(i_port_width), .i_data(wdata), .o_data(o_data),
      .o_data_oe_n(o_data_oe_n), .o_ack_n(o_ack_n), .o_exec_start(o_exec_start), .o_exec_cmd(o_exec_cmd),
      .o_exec_operand(o_exec_operand), .i_exec_accept(i_exec_accept), .i_exec_busy(i_exec_busy),
      .i_exec_short(i_exec_short), .o_exec_halt(o_exec_halt), .o_exec_resume(o_exec_resume),
      .o_exec_reset(o_exec_reset), .o_word_idx(o_word_idx), .i_word(i_word), .o_state_load(o_state_load),
      .o_load_idx(), .o_load_word());
   fcb_host_model i_host (.i_clk(i_clk), .i_ack_n(o_ack_n), .i_rdata(o_data), .o_cs_n(cs_n), .o_ds_n(ds_n),
      .o_rw(rw), .o_addr(addr), .o_data(wdata));
   // Result words: a marker above the index
   assign i_word = {26'h2a5a5a5, o_word_idx};
   // Execution unit model: random accept, busy six cycles after it
   always @(posedge i_clk) begin
      #1;
      i_exec_accept = o_exec_start && !hold_acc && ($urandom % 2 == 1);
      if (i_exec_accept) bcnt = 6;
      else if (bcnt > 0) bcnt--;
      i_exec_busy = hold_busy || bcnt > 0;
      loads += o_state_load;
      resumes += o_exec_resume;
      resets += o_exec_reset;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
      logic [1:0] ack;
      i_host.access(wr, idx, wd, lanes, rd, ack);
      chk(32'(ack), 32'(lanes == 4 ? ACK_8_N : lanes == 2 ? ACK_16_N : ACK_32_N));
   endtask : acc
   // Read response until no wait, bounded
   task automatic poll(input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         acc(1'b0, IDX_RESPONSE, 32'h0);
         n++;
      end while (rd === RSP_WAIT && n < 60);
      chk(rd, exp);
   endtask : poll
   function automatic int nwords(input logic [2:0] f);
      return (f == FMT_DOUBLE) ? 2 : (f == FMT_EXTENDED || f == FMT_PACKED) ? 3 : 1;
   endfunction : nwords
   // One instruction: load operands or store results
   task automatic op(input logic dir, input logic [2:0] f);
      int nw;
      nw = nwords(f);
      cmd = {2'h0, dir, f, 10'($urandom)};
      acc(1'b1, IDX_COMMAND, {16'h0, cmd});
      if (!dir) begin
         acc(1'b0, IDX_RESPONSE, 32'h0);
         chk(rd, RSP_XFER_IN | 32'(nw));
         for (int k = 0; k < nw; k++) begin
            q.push_back($urandom);
            acc(1'b1, IDX_OPERAND, q[$]);
         end
         if (hold_acc) begin
            repeat (2) begin
               acc(1'b0, IDX_RESPONSE, 32'h0);
               chk(rd, RSP_WAIT);
            end
            chk(32'(o_exec_start), 32'h1);
            hold_acc = 1'b0;
         end
         poll(RSP_NULL_GO);
         for (int k = 0; k < nw; k++) chk(o_exec_operand[32*k +: 32], q[$-k]);
      end else begin
         poll(RSP_XFER_OUT | 32'(nw));
         for (int k = 0; k < nw; k++) begin
            acc(1'b0, IDX_OPERAND, 32'h0);
            chk(32'(rd[31:6]), 32'h2a5a5a5);
         end
         poll(RSP_NULL_DONE);
      end
      chk(32'(o_exec_cmd), 32'(cmd));
   endtask : op
   // Save a frame, then restore it
   task automatic save_restore(input logic [7:0] words, input logic halt);
      logic [31:0] held[$];
      acc(1'b0, IDX_SAVE, 32'h0);
      frame = rd;
      chk(frame, {FRAME_VERSION, words, cmd});
      chk(32'(o_exec_halt), 32'(halt));
      for (int k = 1; k < words; k++) begin
         acc(1'b0, IDX_OPERAND, 32'h0);
         held.push_back(rd);
      end
      loads = 0;
      acc(1'b1, IDX_RESTORE, frame);
      foreach (held[k]) acc(1'b1, IDX_OPERAND, held[k]);
      chk(32'(loads), 32'(words) - 32'h1);
   endtask : save_restore
   task automatic stop_test;
      num_errors += i_host.timeouts;
      if (num_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      void'($urandom(85));
      repeat (12) @(posedge i_clk);
      #1;
      i_reset_n = 1'b1;
      chk(32'(o_ack_n), 32'(ACK_NONE_N));
      acc(1'b0, IDX_SAVE, 32'h0);
      chk(rd, 32'h0);
      for (int w = 2; w >= 0; w--) begin
         i_port_width = 2'(w);
         lanes = 1 << w;
         acc(1'b1, IDX_CONTROL, 32'h1);
         acc(1'b0, IDX_CONTROL, 32'h0);
         chk(32'(rd[9]), 32'h1);
         acc(1'b1, IDX_CONTROL, 32'h0);
      end
      hold_acc = 1'b1;
      op(1'b0, FMT_SINGLE);
      for (int f = 0; f < 7; f++) op(1'b0, 3'(f));
      op(1'b1, FMT_DOUBLE);
      save_restore(IDLE_WORDS, 1'b0);
      hold_busy = 1'b1;
      op(1'b0, FMT_LONG);
      resumes = 0;
      save_restore(BUSY_WORDS, 1'b1);
      chk(32'(resumes), 32'h1);
      hold_busy = 1'b0;
      op(1'b0, FMT_WORD);
      {hold_busy, i_exec_short} = 2'b11;
      fork
         begin
            repeat (40) @(posedge i_clk);
            #1;
            hold_busy = 1'b0;
         end
      join_none
      save_restore(IDLE_WORDS, 1'b0);
      i_exec_short = 1'b0;
      resets = 0;
      acc(1'b1, IDX_RESTORE, 32'h0);
      chk(32'(resets), 32'h1);
      acc(1'b0, IDX_SAVE, 32'h0);
      chk(rd, 32'h0);
      stop_test;
   end
   // Watchdog
   initial begin
      repeat (40000) @(posedge i_clk);
      num_errors++;
      stop_test;
   end
endmodule : tb_fcb_host_bus_unit
bind fcb_host_bus_unit fcb_host_bus_unit_sva i_sva (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
   .i_ds_n(i_ds_n), .i_port_width(i_port_width), .o_data_oe_n(o_data_oe_n), .o_ack_n(o_ack_n),
   .o_exec_start(o_exec_start), .o_exec_cmd(o_exec_cmd), .o_exec_operand(o_exec_operand),
   .i_exec_accept(i_exec_accept), .o_exec_halt(o_exec_halt), .o_exec_resume(o_exec_resume),
   .o_exec_reset(o_exec_reset), .o_state_load(o_state_load));
`default_nettype wire
